// ### hdl/threshold_relay_consts.vh
// constants for the threshold relay and peak hold block
`ifndef THRESHOLD_RELAY_CONSTS_VH
`define THRESHOLD_RELAY_CONSTS_VH
`define VAL_W           16
`define HOLD_W          16
`define DLY_W           16
`define BAND_MAX        16'h03e7
`define MODE_UNUSED     2'h0
`define MODE_ONE_ON     2'h1
`define MODE_ONE_OFF    2'h2
`define MODE_TWO        2'h3
`define FAULT_KEEP      2'h0
`define FAULT_ON        2'h1
`define FAULT_OFF       2'h2
`define VIEW_REAL       1'b0
`define VIEW_LATCH      1'b1
`define TB_MS_NS        1000000
`define TB_S_NS         1000000000
`define CLK_NS          10
`define TB_MS_CYC       (`TB_MS_NS / `CLK_NS)
`define TB_S_CYC        (`TB_S_NS / `CLK_NS)
`define HOLD_TICK_MS    100
`define BLINK_HALF_MS   250
`endif

// ### hdl/tick_divider.v
// one-cycle enable pulse divider
`timescale 1ns/1ps
module tick_divider #(
    parameter DIV = 100000
) (
    // clock and reset
    input  wire        i_clk_sys,
    input  wire        i_nrst,
    // enable pulse out
    output reg         o_tick
);
    reg  [31:0] cnt_ff;

    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            cnt_ff <= 32'h0;
            o_tick <= 1'b0;
        end else if (cnt_ff >= DIV - 1) begin
            cnt_ff <= 32'h0;
            o_tick <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
            o_tick <= 1'b0;
        end
    end
endmodule

// ### hdl/relay_channel.v
// one relay output channel: zones, dwell delays, fault response
`timescale 1ns/1ps
`include "threshold_relay_consts.vh"
module relay_channel (
    // clock and reset
    input  wire                      i_clk_sys,
    input  wire                      i_nrst,
    // evaluation inputs
    input  wire                      i_eval,
    input  wire signed [`VAL_W-1:0]  i_value,
    input  wire                      i_fault,
    input  wire                      i_tick_ms,
    input  wire                      i_tick_s,
    // configuration
    input  wire        [1:0]         i_mode,
    input  wire                      i_two_outer,
    input  wire signed [`VAL_W-1:0]  i_threshold_one,
    input  wire signed [`VAL_W-1:0]  i_threshold_two,
    input  wire        [`VAL_W-1:0]  i_band_half_width,
    input  wire        [`DLY_W-1:0]  i_on_delay,
    input  wire        [`DLY_W-1:0]  i_off_delay,
    input  wire                      i_unit_s,
    input  wire        [1:0]         i_fault_response,
    // relay state
    output reg                       o_relay
);
    reg         [`DLY_W-1:0] dly_ff;
    reg                      pend_ff;
    reg  signed [17:0]       lo_t;
    reg  signed [17:0]       hi_t;
    reg  signed [17:0]       band;
    reg  signed [17:0]       v;
    reg                      want_valid;
    reg                      want;
    reg         [`DLY_W-1:0] need;
    wire                     tick;

    assign tick = i_unit_s ? i_tick_s : i_tick_ms;

    always @* begin
        v = {{2{i_value[`VAL_W-1]}}, i_value};
        // clamp band to its legal range
        band = (i_band_half_width > `BAND_MAX) ?
               {2'b00, `BAND_MAX} : {2'b00, i_band_half_width};
        // either order of thresholds accepted
        if (i_threshold_one <= i_threshold_two) begin
            lo_t = {{2{i_threshold_one[`VAL_W-1]}}, i_threshold_one};
            hi_t = {{2{i_threshold_two[`VAL_W-1]}}, i_threshold_two};
        end else begin
            lo_t = {{2{i_threshold_two[`VAL_W-1]}}, i_threshold_two};
            hi_t = {{2{i_threshold_one[`VAL_W-1]}}, i_threshold_one};
        end
        want_valid = 1'b0;
        want = o_relay;
        case (i_mode)
            `MODE_ONE_ON, `MODE_ONE_OFF: begin
                // borders at threshold +/- band
                lo_t = {{2{i_threshold_one[`VAL_W-1]}}, i_threshold_one};
                if (v > lo_t + band) begin
                    want_valid = 1'b1;
                    want = (i_mode == `MODE_ONE_ON);
                end else if (v < lo_t - band) begin
                    want_valid = 1'b1;
                    want = (i_mode == `MODE_ONE_OFF);
                end
            end
            `MODE_TWO: begin
                // shared band and delays for both thresholds
                if (v > lo_t + band && v < hi_t - band) begin
                    want_valid = 1'b1;
                    want = ~i_two_outer;
                end else if (v < lo_t - band || v > hi_t + band) begin
                    want_valid = 1'b1;
                    want = i_two_outer;
                end
            end
            default: begin
                want_valid = 1'b1;
                want = 1'b0;
            end
        endcase
        need = want ? i_on_delay : i_off_delay;
    end

    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_relay <= 1'b0;
            dly_ff  <= {`DLY_W{1'b0}};
            pend_ff <= 1'b0;
        end else if (i_fault) begin
            dly_ff  <= {`DLY_W{1'b0}};
            pend_ff <= 1'b0;
            case (i_fault_response)
                `FAULT_ON:  o_relay <= 1'b1;
                `FAULT_OFF: o_relay <= 1'b0;
                default:    o_relay <= o_relay;
            endcase
        end else if (i_eval) begin
            pend_ff <= 1'b0;
            if (i_mode == `MODE_UNUSED) begin
                o_relay <= 1'b0;
                dly_ff  <= {`DLY_W{1'b0}};
            end else if (!want_valid || want == o_relay) begin
                // back in band or no change: drop pending
                dly_ff <= {`DLY_W{1'b0}};
            end else if (need == {`DLY_W{1'b0}}) begin
                o_relay <= want;
            end else if (dly_ff >= need) begin
                o_relay <= want;
                dly_ff  <= {`DLY_W{1'b0}};
            end else begin
                pend_ff <= 1'b1;
                if (tick)
                    dly_ff <= dly_ff + {{(`DLY_W-1){1'b0}}, 1'b1};
            end
        end else if (pend_ff && tick) begin
            // time runs between samples, not only on them
            dly_ff <= dly_ff + {{(`DLY_W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// ### hdl/threshold_relay_peak.v
// threshold relay control with peak detection and hold
// Function
// - peak needs rise then fall by min swing
// - held peak replaces live value for hold
// - new peak replaces held, restarts hold counter
// - hold expiry returns to live value
// - latched style, zero hold: keep until escape
// - real-time style, zero hold: no holding
// - blink rightmost decimal point while holding
// - per output choose live or peak value
// - mode selects unused, one or two thresholds
// - one threshold: on or off above border
// - borders are threshold plus/minus band
// - zero delays switch immediately at border
// - on delay needs continuous stay beyond border
// - release delay elapses before de-energising
// - leaving zone early cancels pending change
// - fault forces on, off or keeps output
// - two thresholds: on in inner or outer
// - thresholds accepted in either order
// - one band, mode, delays, fault for both
// - indicator LED mirrors relay state
// - config writes never pause evaluation
// - unused mode keeps output off, unless a fault with the on response forces it on
// - band half-width 0 to 999
`timescale 1ns/1ps
`include "threshold_relay_consts.vh"
module threshold_relay_peak #(
    parameter N_OUT         = 2,
    parameter MS_DIV        = `TB_MS_CYC,
    parameter S_DIV         = `TB_S_CYC,
    parameter HOLD_TICK_DIV = `HOLD_TICK_MS * `TB_MS_CYC,
    parameter BLINK_DIV     = `BLINK_HALF_MS * `TB_MS_CYC
) (
    // clock and reset
    input  wire                        i_clk_sys,
    input  wire                        i_nrst,
    // measurement
    input  wire                        i_sample_valid,
    input  wire signed [`VAL_W-1:0]    i_sample,
    input  wire                        i_fault,
    input  wire                        i_escape,
    // peak configuration
    input  wire        [`VAL_W-1:0]    i_peak_min_swing,
    input  wire        [`HOLD_W-1:0]   i_hold_time,
    input  wire                        i_peak_view_style,
    // per output configuration, packed by output index
    input  wire        [N_OUT-1:0]     i_use_peak,
    input  wire        [2*N_OUT-1:0]   i_mode,
    input  wire        [N_OUT-1:0]     i_two_outer,
    input  wire        [`VAL_W*N_OUT-1:0] i_threshold_one,
    input  wire        [`VAL_W*N_OUT-1:0] i_threshold_two,
    input  wire        [`VAL_W*N_OUT-1:0] i_band_half_width,
    input  wire        [`DLY_W*N_OUT-1:0] i_on_delay,
    input  wire        [`DLY_W*N_OUT-1:0] i_off_delay,
    input  wire        [N_OUT-1:0]     i_unit_s,
    input  wire        [2*N_OUT-1:0]   i_fault_response,
    // results
    output reg  signed [`VAL_W-1:0]    o_display_value,
    output reg                         o_peak_dp,
    output wire        [N_OUT-1:0]     o_relay,
    output wire        [N_OUT-1:0]     o_led
);
    // synchronisers for pin-level inputs
    reg  [1:0]               fault_sync_ff;
    reg  [1:0]               esc_sync_ff;
    reg                      esc_prev_ff;
    wire                     fault_s;
    wire                     esc_pulse;

    // peak tracking
    reg  signed [`VAL_W-1:0] ext_ff;
    reg                      rising_ff;
    reg  signed [`VAL_W-1:0] held_ff;
    reg                      holding_ff;
    reg  [`HOLD_W-1:0]       hold_cnt_ff;
    reg                      eval_ff;
    reg  signed [`VAL_W-1:0] live_ff;
    reg                      blink_ff;
    reg  signed [17:0]       rise_amt;
    reg  signed [17:0]       fall_amt;
    reg  signed [17:0]       swing;
    reg                      peak_found;
    wire                     tick_ms;
    wire                     tick_s;
    wire                     tick_hold;
    wire                     tick_blink;

    assign fault_s   = fault_sync_ff[1];
    assign esc_pulse = esc_sync_ff[1] & ~esc_prev_ff;

    tick_divider #(.DIV(MS_DIV)) u_ms (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .o_tick    (tick_ms)
    );
    tick_divider #(.DIV(S_DIV)) u_s (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .o_tick    (tick_s)
    );
    tick_divider #(.DIV(HOLD_TICK_DIV)) u_hold (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .o_tick    (tick_hold)
    );
    tick_divider #(.DIV(BLINK_DIV)) u_blink (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .o_tick    (tick_blink)
    );

    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            fault_sync_ff <= 2'h0;
            esc_sync_ff   <= 2'h0;
            esc_prev_ff   <= 1'b0;
        end else begin
            fault_sync_ff <= {fault_sync_ff[0], i_fault};
            esc_sync_ff   <= {esc_sync_ff[0], i_escape};
            esc_prev_ff   <= esc_sync_ff[1];
        end
    end

    // swing measured from the running extreme
    always @*begin
        swing    = {2'b00, i_peak_min_swing};
        rise_amt = {{2{i_sample[`VAL_W-1]}}, i_sample}
                 - {{2{ext_ff[`VAL_W-1]}}, ext_ff};
        fall_amt = {{2{ext_ff[`VAL_W-1]}}, ext_ff}
                 - {{2{i_sample[`VAL_W-1]}}, i_sample};
        peak_found = i_sample_valid && rising_ff
                   && fall_amt >= swing;
    end

    // peak detector: track max while rising, min while falling
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            ext_ff    <= {`VAL_W{1'b0}};
            rising_ff <= 1'b0;
        end else if (i_sample_valid) begin
            if (rising_ff) begin
                if (peak_found) begin
                    rising_ff <= 1'b0;
                    ext_ff    <= i_sample;
                end else if (i_sample > ext_ff) begin
                    ext_ff <= i_sample;
                end
            end else if (rise_amt >= swing) begin
                // climbed enough above trough to arm next peak
                rising_ff <= 1'b1;
                ext_ff    <= i_sample;
            end else if (i_sample < ext_ff) begin
                ext_ff <= i_sample;
            end
        end
    end

    // hold control; zero hold behaviour depends on view style
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            held_ff     <= {`VAL_W{1'b0}};
            holding_ff  <= 1'b0;
            hold_cnt_ff <= {`HOLD_W{1'b0}};
        end else if (peak_found && (i_hold_time != {`HOLD_W{1'b0}} ||
                     i_peak_view_style == `VIEW_LATCH)) begin
            held_ff     <= ext_ff;
            holding_ff  <= 1'b1;
            hold_cnt_ff <= {`HOLD_W{1'b0}};
        end else if (holding_ff) begin
            if (i_hold_time == {`HOLD_W{1'b0}}) begin
                if (i_peak_view_style == `VIEW_REAL || esc_pulse)
                    holding_ff <= 1'b0;
            end else if (hold_cnt_ff >= i_hold_time) begin
                holding_ff <= 1'b0;
            end else if (tick_hold) begin
                hold_cnt_ff <= hold_cnt_ff + {{(`HOLD_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // display value and blinking point
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            live_ff         <= {`VAL_W{1'b0}};
            eval_ff         <= 1'b0;
            blink_ff        <= 1'b0;
            o_display_value <= {`VAL_W{1'b0}};
            o_peak_dp       <= 1'b0;
        end else begin
            // config inputs are read live, nothing stalls
            if (i_sample_valid)
                live_ff <= i_sample;
            eval_ff <= i_sample_valid;
            if (tick_blink)
                blink_ff <= ~blink_ff;
            o_display_value <= holding_ff ? held_ff : live_ff;
            o_peak_dp       <= holding_ff & blink_ff;
        end
    end

    // per output channels; LED is the relay state
    genvar g;
    generate
        for (g = 0; g < N_OUT; g = g + 1) begin : g_ch
            wire signed [`VAL_W-1:0] src;
            assign src = (i_use_peak[g] && holding_ff) ?
                         held_ff : live_ff;
            relay_channel u_ch (
                .i_clk_sys         (i_clk_sys),
                .i_nrst            (i_nrst),
                .i_eval            (eval_ff),
                .i_value           (src),
                .i_fault           (fault_s),
                .i_tick_ms         (tick_ms),
                .i_tick_s          (tick_s),
                .i_mode            (i_mode[2*g+1:2*g]),
                .i_two_outer       (i_two_outer[g]),
                .i_threshold_one   (i_threshold_one[`VAL_W*g +: `VAL_W]),
                .i_threshold_two   (i_threshold_two[`VAL_W*g +: `VAL_W]),
                .i_band_half_width (i_band_half_width[`VAL_W*g +: `VAL_W]),
                .i_on_delay        (i_on_delay[`DLY_W*g +: `DLY_W]),
                .i_off_delay       (i_off_delay[`DLY_W*g +: `DLY_W]),
                .i_unit_s          (i_unit_s[g]),
                .i_fault_response  (i_fault_response[2*g+1:2*g]),
                .o_relay           (o_relay[g])
            );
            assign o_led[g] = o_relay[g];
        end
    endgenerate
endmodule

// ### tb/relay_panel_model.sv
// relay driver and indicator panel model
`timescale 1ns/1ps
module relay_panel_model (
    // clock
    input  wire       i_clk_sys,
    // coil and lamp drive from the block
    input  wire [1:0] i_relay,
    input  wire [1:0] i_led,
    // contact state and lamp mismatch flag
    output reg  [1:0] o_contact,
    output reg        o_lamp_err
);
    initial o_lamp_err = 1'b0;
    // contacts lag the coil by one clock, like a real driver stage
    always @(posedge i_clk_sys) begin
        o_contact <= i_relay;
        if (i_led !== i_relay) o_lamp_err <= 1'b1;
    end
endmodule

// ### tb/threshold_relay_peak_assertions.sv
// port-level checks for the threshold relay block
`timescale 1ns/1ps
module threshold_relay_peak_checker #(
    parameter N_OUT = 2
) (
    // clock and reset
    input wire                      i_clk_sys,
    input wire                      i_nrst,
    // measurement and configuration
    input wire                      i_sample_valid,
    input wire signed [15:0]        i_sample,
    input wire                      i_fault,
    input wire        [15:0]        i_hold_time,
    input wire                      i_peak_view_style,
    input wire        [N_OUT-1:0]   i_use_peak,
    input wire        [2*N_OUT-1:0] i_mode,
    input wire        [16*N_OUT-1:0] i_threshold_one,
    input wire        [16*N_OUT-1:0] i_band_half_width,
    input wire        [16*N_OUT-1:0] i_on_delay,
    input wire        [16*N_OUT-1:0] i_off_delay,
    input wire        [2*N_OUT-1:0] i_fault_response,
    // results
    input wire signed [15:0]        o_display_value,
    input wire                      o_peak_dp,
    input wire        [N_OUT-1:0]   o_relay,
    input wire        [N_OUT-1:0]   o_led
);
    reg         [3:0]  quiet_ff = 4'h0;
    // fault passes a two stage sync, so wait well past it
    wire        [3:0]  nxt_quiet = (!i_nrst || i_fault) ? 4'h0 :
                                   quiet_ff + (quiet_ff != 4'hf);
    wire               quiet = quiet_ff > 4'h7;
    wire signed [17:0] up0 = $signed(i_threshold_one[15:0]) +
                             $signed({2'h0, i_band_half_width[15:0]});
    wire               above0 = $signed(i_sample) > up0;
    always @(posedge i_clk_sys) begin
        quiet_ff <= nxt_quiet;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    led_mirror_a: assert property (o_led == o_relay)
        else $error("indicator differs from relay");
    unused_off_a: assert property (
        i_sample_valid && i_mode[1:0] == 2'h0 && quiet |-> ##3 !o_relay[0])
        else $error("unused channel energised");
    imm_on_a: assert property (
        i_sample_valid && i_mode[1:0] == 2'h1 && i_on_delay[15:0] == 16'h0
        && i_off_delay[15:0] == 16'h0 && !i_use_peak[0] && quiet && above0
        |-> ##3 o_relay[0]) else $error("relay not on above border");
    rise_cause_a: assert property (
        $rose(o_relay[0]) && $past(i_mode[1:0], 2) == 2'h1
        && !i_use_peak[0] && quiet |-> $past(i_sample_valid && above0, 2))
        else $error("relay rose without a sample above border");
    live_view_a: assert property (
        i_sample_valid && !i_peak_view_style && i_hold_time == 16'h0 ##1
        (!i_peak_view_style && i_hold_time == 16'h0)[*2]
        |=> o_display_value == $past(i_sample, 3))
        else $error("display not live with zero hold");
    no_blink_a: assert property (
        (!i_peak_view_style && i_hold_time == 16'h0)[*8] |-> !o_peak_dp)
        else $error("point blinks with no hold");
    fault_on_a: assert property (
        (i_fault && i_sample_valid && i_fault_response[1:0] == 2'h1)[*7]
        |-> o_relay[0]) else $error("fault did not force relay on");
    fault_off_a: assert property (
        (i_fault && i_sample_valid && i_fault_response[3:2] == 2'h2)[*7]
        |-> !o_relay[1]) else $error("fault did not force relay off");
    cover property (o_peak_dp);
    cover property (i_fault && o_relay[0]);
    cover property ($fell(o_relay[0]) && quiet);
endmodule

bind threshold_relay_peak threshold_relay_peak_checker #(.N_OUT(N_OUT)) chk_i (
    .i_clk_sys, .i_nrst, .i_sample_valid, .i_sample, .i_fault,
    .i_hold_time, .i_peak_view_style, .i_use_peak, .i_mode,
    .i_threshold_one, .i_band_half_width, .i_on_delay, .i_off_delay,
    .i_fault_response, .o_display_value, .o_peak_dp, .o_relay, .o_led);

// ### tb/threshold_relay_peak_test.sv
// self-checking bench for threshold relay with peak hold
`timescale 1ns/1ps
module threshold_relay_peak_test;
    reg         clk = 0, nrst = 0, vld = 0, flt = 0, esc = 0, sty = 0;
    reg  [15:0] smp = 0, swing = 16'h7fff, hold = 0;
    reg  [1:0]  upk = 0, outr = 0, us = 0;
    reg  [3:0]  mode = 0, fr = 0;
    reg  [31:0] th1 = 0, th2 = 0, bw = 0, ond = 0, offd = 0;
    wire [15:0] disp;
    wire [1:0]  rly, led, cont;
    wire        dp, lamp_err;
    integer     error_cnt = 0, samples_checked = 0;
    integer     lf = 38318, i, k, r, a, b, w, v;
    integer     st [0:1];
    threshold_relay_peak #(.MS_DIV(4), .S_DIV(16), .HOLD_TICK_DIV(8),
        .BLINK_DIV(4)) dut (.i_clk_sys(clk), .i_nrst(nrst),
        .i_sample_valid(vld), .i_sample(smp), .i_fault(flt),
        .i_escape(esc), .i_peak_min_swing(swing), .i_hold_time(hold),
        .i_peak_view_style(sty), .i_use_peak(upk), .i_mode(mode),
        .i_two_outer(outr), .i_threshold_one(th1),
        .i_threshold_two(th2), .i_band_half_width(bw),
        .i_on_delay(ond), .i_off_delay(offd), .i_unit_s(us),
        .i_fault_response(fr), .o_display_value(disp),
        .o_peak_dp(dp), .o_relay(rly), .o_led(led));
    relay_panel_model panel (.i_clk_sys(clk), .i_relay(rly),
        .i_led(led), .o_contact(cont), .o_lamp_err(lamp_err));
    initial begin
        forever #5 clk = ~clk;
    end
    function integer nx(input integer x);
        nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // zero-delay relay model: band keeps the previous state
    function integer model_relay(input integer m, t, u, h, o, x, s);
        integer lo, hi, z;
        begin
            lo = t < u ? t : u;
            hi = t < u ? u : t;
            if (m != 3) z = x > t + h ? 1 : x < t - h ? 0 : -1;
            else if (x > lo + h && x < hi - h) z = 1;
            else z = (x < lo - h || x > hi + h) ? 0 : -1;
            if (z >= 0 && (m == 2 || (m == 3 && o))) z = 1 - z;
            model_relay = m == 0 ? 0 : z < 0 ? s : z;
        end
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // one sample per cycle for n cycles
    task feed(input integer x, input integer n);
        begin
            @(posedge clk);
            smp <= x;
            vld <= 1'b1;
            repeat (n) @(posedge clk);
            vld <= 1'b0;
        end
    endtask
    task settle;
        begin
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", samples_checked, error_cnt);
            if (error_cnt == 0 && samples_checked > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // whole run is about 1600 cycles, allow over fifteen times that
    initial begin
        #250000;
        error_cnt = error_cnt + 1;
        wrap_up;
    end
    initial begin
        st[0] = 0;
        st[1] = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        upk <= 2'b01;
        mode <= 4'h5;
        th1 <= {16'd40, 16'd40};
        bw <= {16'd2, 16'd2};
        swing <= 16'd20;
        hold <= 16'd8;
        feed(0, 4);
        feed(50, 2);
        feed(25, 3);
        settle;
        chk(disp, 50);
        chk(rly, 1);
        k = 0;
        repeat (8) begin
            @(posedge clk);
            #1 k = k | dp;
        end
        chk(k, 1);
        feed(25, 60);
        settle;
        chk(disp, 25);
        // second peak before the middle of the first hold must restart it
        feed(60, 2);
        feed(30, 24);
        feed(55, 2);
        feed(30, 2);
        repeat (42) @(posedge clk);
        #1 chk(disp, 55);
        $display("timed hold test done");
        @(posedge clk);
        sty <= 1'b1;
        hold <= 16'h0;
        feed(60, 2);
        feed(25, 2);
        feed(10, 100);
        settle;
        chk(disp, 60);
        @(posedge clk);
        esc <= 1'b1;
        repeat (4) @(posedge clk);
        esc <= 1'b0;
        feed(10, 2);
        settle;
        chk(disp, 10);
        @(posedge clk);
        sty <= 1'b0;
        feed(40, 2);
        feed(15, 2);
        settle;
        chk(disp, 15);
        $display("zero hold test done");
        @(posedge clk);
        upk <= 2'b00;
        swing <= 16'h7fff;
        for (i = 0; i < 240; i = i + 1) begin
            if (i % 12 == 0) begin
                @(posedge clk);
                for (k = 0; k < 2; k = k + 1) begin
                    lf = nx(lf);
                    a = lf % 301 - 150;
                    lf = nx(lf);
                    w = lf % 40;
                    lf = nx(lf);
                    b = lf[0] ? a + 2 * w + 5 + lf % 60 : a - 2 * w - 5;
                    mode[2*k+:2] <= lf[2:1];
                    outr[k] <= lf[3];
                    th1[16*k+:16] <= a;
                    th2[16*k+:16] <= b;
                    bw[16*k+:16] <= w;
                end
                repeat (2) @(posedge clk);
            end
            lf = nx(lf);
            v = lf % 400 - 200;
            feed(v, 1);
            settle;
            chk(disp, v);
            for (k = 0; k < 2; k = k + 1) begin
                st[k] = model_relay(mode[2*k+:2], $signed(th1[16*k+:16]),
                    $signed(th2[16*k+:16]), bw[16*k+:16], outr[k], v, st[k]);
                chk(rly[k], st[k]);
                chk(led[k], st[k]);
            end
        end
        $display("random zone test done");
        @(posedge clk);
        mode <= 4'h1;
        th1 <= 32'h0;
        bw <= 32'd10;
        ond <= 32'd3;
        offd <= 32'd3;
        feed(-100, 30);
        feed(100, 5);
        settle;
        chk(rly[0], 0);
        feed(100, 20);
        settle;
        chk(rly[0], 1);
        feed(-100, 3);
        feed(100, 30);
        settle;
        chk(rly[0], 1);
        feed(-100, 20);
        settle;
        chk(rly[0], 0);
        // second-based ticks: 30 samples are too few for 3 ticks
        @(posedge clk);
        us <= 2'b01;
        feed(100, 30);
        settle;
        chk(rly[0], 0);
        feed(100, 40);
        settle;
        chk(rly[0], 1);
        $display("delay test done");
        @(posedge clk);
        mode <= 4'h9;
        ond <= 32'h0;
        offd <= 32'h0;
        us <= 2'b00;
        bw <= {16'd10, 16'hffff};
        feed(-1100, 2);
        settle;
        chk(rly[0], 0);
        @(posedge clk);
        bw <= {16'd10, 16'd10};
        for (r = 0; r < 4; r = r + 1) begin
            fr <= {r[1:0], r[1:0]};
            feed(-100, 8);
            @(posedge clk);
            flt <= 1'b1;
            feed(-100, 8);
            settle;
            chk(rly, {r != 2, r == 1});
            @(posedge clk);
            flt <= 1'b0;
        end
        chk(lamp_err, 0);
        chk(cont, rly);
        $display("fault test done");
        wrap_up;
    end
endmodule
